// file: common/bcv_pkg.sv
// Shared constants and carrier types for the bridge control upper-field block
package bcv_pkg;

	// ----------------------------------------
	// Register placement
	// ----------------------------------------
	localparam logic [5:0] BCV_CTRL_DWORD = 6'h0f;
	localparam int BCV_LANE2 = 2;
	localparam int BCV_LANE3 = 3;
	localparam logic [31:0] BCV_CTRL_RESET = 32'h0000_0000;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BCV_VGA_EN_BIT = 19;
	localparam int BCV_MA_MODE_BIT = 21;
	localparam int BCV_SEC_RST_BIT = 22;
	localparam int BCV_FB2B_BIT = 23;
	localparam int BCV_PRI_SEL_BIT = 24;
	localparam int BCV_SEC_SEL_BIT = 25;
	localparam int BCV_DISC_STAT_BIT = 26;
	localparam int BCV_DISC_SERR_BIT = 27;

	// ----------------------------------------
	// Discard timer lengths in clock cycles
	// ----------------------------------------
	localparam int BCV_LONG_CYCLES = 32768;
	localparam int BCV_SHORT_CYCLES = 1024;
	localparam int BCV_TIMER_W = 16;

	// ----------------------------------------
	// Legacy video address ranges
	// ----------------------------------------
	localparam logic [31:0] BCV_VGA_MEM_LO = 32'h000a_0000;
	localparam logic [31:0] BCV_VGA_MEM_HI = 32'h000b_ffff;
	localparam logic [9:0] BCV_VGA_IO1_LO = 10'h3b0;
	localparam logic [9:0] BCV_VGA_IO1_HI = 10'h3bb;
	localparam logic [9:0] BCV_VGA_IO2_LO = 10'h3c0;
	localparam logic [9:0] BCV_VGA_IO2_HI = 10'h3df;
	localparam logic [15:0] BCV_IO_UPPER_ZERO = 16'h0000;
	localparam logic [31:0] BCV_ALL_ONES = 32'hffff_ffff;

	// ----------------------------------------
	// Carrier types
	// ----------------------------------------
	typedef struct packed {
		logic valid;
		logic is_mem;
		logic is_io;
		logic [31:0] addr;
	} bcv_addr_t;

	typedef struct packed {
		logic valid;
		logic delayed;
		logic posted;
		logic read;
	} bcv_abort_t;

	typedef struct packed {
		logic complete_ok;
		logic target_abort;
		logic [31:0] rdata;
	} bcv_abort_resp_t;

	typedef enum logic [2:0] {
		BCV_T_IDLE = 3'b001,
		BCV_T_COUNT = 3'b010,
		BCV_T_DONE = 3'b100
	} bcv_timer_state_t;

endpackage

// file: design/bcv_vga_decode.sv
// Legacy video range decoder for one bus side
`timescale 1ns/1ps
module bcv_vga_decode (
	// Transaction address
	input bcv_pkg::bcv_addr_t req,
	// Range hits
	output logic mem_hit,
	output logic io_hit
);
	import bcv_pkg::*;

	logic io_low1;
	logic io_low2;

	always_comb begin
		mem_hit = req.valid && req.is_mem &&
			(req.addr >= BCV_VGA_MEM_LO) && (req.addr <= BCV_VGA_MEM_HI);
		// Bits 15:10 are deliberately left out of the compare
		io_low1 = (req.addr[9:0] >= BCV_VGA_IO1_LO) && (req.addr[9:0] <= BCV_VGA_IO1_HI);
		io_low2 = (req.addr[9:0] >= BCV_VGA_IO2_LO) && (req.addr[9:0] <= BCV_VGA_IO2_HI);
		io_hit = req.valid && req.is_io && (req.addr[31:16] == BCV_IO_UPPER_ZERO) &&
			(io_low1 || io_low2);
	end

endmodule // bcv_vga_decode

// file: design/bcv_discard_timer.sv
// Discard timer for delayed completions awaiting a repeated request
`timescale 1ns/1ps
module bcv_discard_timer #(
	parameter int LONG_CYCLES = bcv_pkg::BCV_LONG_CYCLES,
	parameter int SHORT_CYCLES = bcv_pkg::BCV_SHORT_CYCLES,
	parameter int W = bcv_pkg::BCV_TIMER_W
) (
	// Clock and resets
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clr,
	// Queue head and selection
	input wire logic head_valid,
	input wire logic repeat_seen,
	input wire logic short_sel,
	// Expiry pulse
	output logic discard
);
	import bcv_pkg::*;

	bcv_timer_state_t state;
	bcv_timer_state_t next_state;
	logic [W-1:0] count;
	logic [W-1:0] next_count;
	logic next_discard;

	always_comb begin
		next_state = state;
		next_count = count;
		next_discard = 1'b0;
		unique case (state)
			BCV_T_IDLE: begin
				if (head_valid && !repeat_seen) begin
					next_state = BCV_T_COUNT;
					next_count = short_sel ? W'(SHORT_CYCLES - 1) : W'(LONG_CYCLES - 1);
				end
			end
			BCV_T_COUNT: begin
				if (repeat_seen || !head_valid) begin
					next_state = BCV_T_IDLE;
					next_count = '0;
				end else if (count == '0) begin
					next_state = BCV_T_DONE;
					next_discard = 1'b1;
				end else begin
					next_count = count - W'(1);
				end
			end
			BCV_T_DONE: begin
				// Wait for the dropped entry to leave the head
				if (!head_valid) begin
					next_state = BCV_T_IDLE;
				end
			end
			default: begin
				next_state = BCV_T_IDLE;
				next_count = '0;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!resetn || clr) begin
			state <= BCV_T_IDLE;
			count <= '0;
			discard <= 1'b0;
		end else begin
			state <= next_state;
			count <= next_count;
			discard <= next_discard;
		end
	end

endmodule // bcv_discard_timer

// file: design/bcv_bridge_ctrl.sv
// Bridge control upper fields: video decode, abort response, reset, discard timers
// Summary of operation
// - Video off: primary video I/O forwarded only inside I/O window with ISA mode 0.
// - Video on: legacy video memory range forwarded when memory enable is set, regardless of window or ISA mode.
// - Video on: video I/O ranges claimed on bits 9:0, upper half zero, 15:10 ignored.
// - Video on: video range transactions are never claimed on the secondary bus.
// - Abort mode 0: delayed completes normally, reads give all ones, no error pin.
// - Abort mode 1: delayed gets target abort; posted write raises error if enabled.
// - Secondary reset bit drives the secondary reset output directly.
// - Secondary reset clears buffers and secondary logic, not primary or config.
// - Fast back-to-back bit reads zero; never generated on the secondary bus.
// - Primary discard counter starts at queue head; expiry drops the transaction.
// - Select bit picks two to the fifteenth or two to the tenth cycles.
// - Independent secondary discard counter with its own select bit.
// - Discard status set on expiry; write one clears, write zero no effect.
// - Discard expiry raises error pin only when both error enables are set.
// - Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
module bcv_bridge_ctrl #(
	parameter int LONG_CYCLES = bcv_pkg::BCV_LONG_CYCLES,
	parameter int SHORT_CYCLES = bcv_pkg::BCV_SHORT_CYCLES
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Configuration access
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [5:0] cfg_dword,
	input wire logic [3:0] cfg_be_n,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_rdata_valid,
	// Command register and neighbouring decode state
	input wire logic cmd_io_enable,
	input wire logic cmd_mem_enable,
	input wire logic system_error_report_enable,
	input wire logic isa_mode,
	input wire logic pri_io_window_hit,
	// Video address decode
	input bcv_pkg::bcv_addr_t pri_req,
	input bcv_pkg::bcv_addr_t sec_req,
	output logic pri_vga_claim,
	output logic sec_vga_ignore,
	// Master abort handling
	input bcv_pkg::bcv_abort_t abort_in,
	output bcv_pkg::bcv_abort_resp_t abort_resp,
	// Discard timers
	input wire logic pri_head_valid,
	input wire logic pri_repeat_seen,
	input wire logic sec_head_valid,
	input wire logic sec_repeat_seen,
	output logic pri_discard,
	output logic sec_discard,
	// Secondary reset and bus options
	output logic sec_reset_n,
	output logic sec_logic_reset_n,
	output logic sec_fast_b2b_en,
	// Primary system error pin, open drain
	output logic primary_system_error_n,
	output logic primary_system_error_oe
);
	import bcv_pkg::*;

	// ----------------------------------------
	// Control register state
	// ----------------------------------------
	logic vga_enable;
	logic ma_mode;
	logic sec_bus_reset;
	logic pri_short_sel;
	logic sec_short_sel;
	logic disc_status;
	logic disc_serr_en;
	logic next_vga_enable;
	logic next_ma_mode;
	logic next_sec_bus_reset;
	logic next_pri_short_sel;
	logic next_sec_short_sel;
	logic next_disc_status;
	logic next_disc_serr_en;
	logic [31:0] next_cfg_rdata;
	logic next_cfg_rdata_valid;
	logic hit;
	logic wr_lane2;
	logic wr_lane3;
	logic [31:0] ctrl_view;

	// ----------------------------------------
	// Secondary-side and datapath state
	// ----------------------------------------
	logic pri_mem_hit;
	logic pri_io_hit;
	logic sec_mem_hit;
	logic sec_io_hit;
	logic pri_disc_raw;
	logic sec_disc_raw;
	logic any_discard;
	logic next_pri_vga_claim;
	logic next_sec_vga_ignore;
	bcv_abort_resp_t next_abort_resp;
	logic next_serr;

	// ----------------------------------------
	// Register access
	// ----------------------------------------
	always_comb begin
		hit = (cfg_dword == BCV_CTRL_DWORD);
		wr_lane2 = cfg_wr && hit && !cfg_be_n[BCV_LANE2];
		wr_lane3 = cfg_wr && hit && !cfg_be_n[BCV_LANE3];
		ctrl_view = BCV_CTRL_RESET;
		ctrl_view[BCV_VGA_EN_BIT] = vga_enable;
		ctrl_view[BCV_MA_MODE_BIT] = ma_mode;
		ctrl_view[BCV_SEC_RST_BIT] = sec_bus_reset;
		ctrl_view[BCV_FB2B_BIT] = 1'b0;
		ctrl_view[BCV_PRI_SEL_BIT] = pri_short_sel;
		ctrl_view[BCV_SEC_SEL_BIT] = sec_short_sel;
		ctrl_view[BCV_DISC_STAT_BIT] = disc_status;
		ctrl_view[BCV_DISC_SERR_BIT] = disc_serr_en;

		next_vga_enable = vga_enable;
		next_ma_mode = ma_mode;
		next_sec_bus_reset = sec_bus_reset;
		next_pri_short_sel = pri_short_sel;
		next_sec_short_sel = sec_short_sel;
		next_disc_serr_en = disc_serr_en;
		next_disc_status = disc_status;
		if (wr_lane2) begin
			next_vga_enable = cfg_wdata[BCV_VGA_EN_BIT];
			next_ma_mode = cfg_wdata[BCV_MA_MODE_BIT];
			next_sec_bus_reset = cfg_wdata[BCV_SEC_RST_BIT];
		end
		if (wr_lane3) begin
			next_pri_short_sel = cfg_wdata[BCV_PRI_SEL_BIT];
			next_sec_short_sel = cfg_wdata[BCV_SEC_SEL_BIT];
			next_disc_serr_en = cfg_wdata[BCV_DISC_SERR_BIT];
			if (cfg_wdata[BCV_DISC_STAT_BIT]) begin
				next_disc_status = 1'b0;
			end
		end
		// A discard in the clearing cycle keeps the flag set
		if (any_discard) begin
			next_disc_status = 1'b1;
		end

		// Reads of any other dword return zero
		next_cfg_rdata_valid = cfg_rd;
		next_cfg_rdata = (cfg_rd && hit) ? ctrl_view : 32'h0000_0000;
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			vga_enable <= 1'b0;
			ma_mode <= 1'b0;
			sec_bus_reset <= 1'b0;
			pri_short_sel <= 1'b0;
			sec_short_sel <= 1'b0;
			disc_status <= 1'b0;
			disc_serr_en <= 1'b0;
			cfg_rdata <= 32'h0000_0000;
			cfg_rdata_valid <= 1'b0;
		end else begin
			vga_enable <= next_vga_enable;
			ma_mode <= next_ma_mode;
			sec_bus_reset <= next_sec_bus_reset;
			pri_short_sel <= next_pri_short_sel;
			sec_short_sel <= next_sec_short_sel;
			disc_status <= next_disc_status;
			disc_serr_en <= next_disc_serr_en;
			cfg_rdata <= next_cfg_rdata;
			cfg_rdata_valid <= next_cfg_rdata_valid;
		end
	end

	// ----------------------------------------
	// Video range decode
	// ----------------------------------------
	bcv_vga_decode u_pri_decode (
		.req(pri_req),
		.mem_hit(pri_mem_hit),
		.io_hit(pri_io_hit)
	);

	bcv_vga_decode u_sec_decode (
		.req(sec_req),
		.mem_hit(sec_mem_hit),
		.io_hit(sec_io_hit)
	);

	always_comb begin
		if (vga_enable) begin
			// Window, ISA mode and snoop play no part here
			next_pri_vga_claim = (pri_mem_hit && cmd_mem_enable) ||
				(pri_io_hit && cmd_io_enable);
		end else begin
			next_pri_vga_claim = pri_io_hit && cmd_io_enable &&
				pri_io_window_hit && !isa_mode;
		end
		// Secondary side: mark what the bridge must leave unclaimed
		next_sec_vga_ignore = vga_enable && (sec_mem_hit || sec_io_hit);
	end

	// ----------------------------------------
	// Master abort response and error pin
	// ----------------------------------------
	always_comb begin
		next_abort_resp = '0;
		next_serr = 1'b0;
		if (abort_in.valid && abort_in.delayed) begin
			if (ma_mode) begin
				next_abort_resp.target_abort = 1'b1;
			end else begin
				next_abort_resp.complete_ok = 1'b1;
				if (abort_in.read) begin
					next_abort_resp.rdata = BCV_ALL_ONES;
				end
			end
		end
		// Posted writes get no bus answer, only the error pin
		if (abort_in.valid && abort_in.posted && ma_mode && system_error_report_enable) begin
			next_serr = 1'b1;
		end
		if (any_discard && disc_serr_en && system_error_report_enable) begin
			next_serr = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			pri_vga_claim <= 1'b0;
			sec_vga_ignore <= 1'b0;
			abort_resp <= '0;
		end else begin
			pri_vga_claim <= next_pri_vga_claim;
			sec_vga_ignore <= next_sec_vga_ignore;
			abort_resp <= next_abort_resp;
		end
	end

	// ----------------------------------------
	// Primary system error pin
	// ----------------------------------------
	// Open drain: the enable is high only while the pin is pulled low
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			primary_system_error_n <= 1'b1;
			primary_system_error_oe <= 1'b0;
		end else begin
			primary_system_error_n <= !next_serr;
			primary_system_error_oe <= next_serr;
		end
	end

	// ----------------------------------------
	// Discard timers
	// ----------------------------------------
	// Secondary reset holds both timers idle: they serve the buffers
	bcv_discard_timer #(
		.LONG_CYCLES(LONG_CYCLES),
		.SHORT_CYCLES(SHORT_CYCLES),
		.W(BCV_TIMER_W)
	) u_pri_timer (
		.core_clk(core_clk),
		.resetn(resetn),
		.clr(sec_bus_reset),
		.head_valid(pri_head_valid),
		.repeat_seen(pri_repeat_seen),
		.short_sel(pri_short_sel),
		.discard(pri_disc_raw)
	);

	bcv_discard_timer #(
		.LONG_CYCLES(LONG_CYCLES),
		.SHORT_CYCLES(SHORT_CYCLES),
		.W(BCV_TIMER_W)
	) u_sec_timer (
		.core_clk(core_clk),
		.resetn(resetn),
		.clr(sec_bus_reset),
		.head_valid(sec_head_valid),
		.repeat_seen(sec_repeat_seen),
		.short_sel(sec_short_sel),
		.discard(sec_disc_raw)
	);

	always_comb begin
		any_discard = pri_disc_raw || sec_disc_raw;
		pri_discard = pri_disc_raw;
		sec_discard = sec_disc_raw;
	end

	// ----------------------------------------
	// Secondary reset and bus options
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			sec_reset_n <= 1'b0;
			sec_logic_reset_n <= 1'b0;
			sec_fast_b2b_en <= 1'b0;
		end else begin
			sec_reset_n <= !next_sec_bus_reset;
			sec_logic_reset_n <= !next_sec_bus_reset;
			sec_fast_b2b_en <= 1'b0;
		end
	end

endmodule // bcv_bridge_ctrl

// file: sim/bcv_bridge_ctrl_props.sv
// Port-level checks for the bridge control block
`timescale 1ns/1ps
module bcv_bridge_ctrl_props #(
	parameter int LONG_CYCLES = bcv_pkg::BCV_LONG_CYCLES,
	parameter int SHORT_CYCLES = bcv_pkg::BCV_SHORT_CYCLES
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Watched ports
	input wire logic cfg_rd,
	input wire logic [31:0] cfg_rdata,
	input wire logic cfg_rdata_valid,
	input bcv_pkg::bcv_addr_t pri_req,
	input bcv_pkg::bcv_addr_t sec_req,
	input wire logic pri_vga_claim,
	input wire logic sec_vga_ignore,
	input bcv_pkg::bcv_abort_t abort_in,
	input bcv_pkg::bcv_abort_resp_t abort_resp,
	input wire logic pri_head_valid,
	input wire logic pri_discard,
	input wire logic sec_reset_n,
	input wire logic sec_logic_reset_n,
	input wire logic sec_fast_b2b_en,
	input wire logic primary_system_error_n,
	input wire logic primary_system_error_oe
);
	import bcv_pkg::*;
	logic [15:0] hold_cnt;
	// Cycles the primary head has waited, saturating
	always_ff @(posedge core_clk) begin
		if (!resetn || !pri_head_valid) begin
			hold_cnt <= 16'h0;
		end else if (hold_cnt != 16'hffff) begin
			hold_cnt <= hold_cnt + 16'h1;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	sequence s_dly_abort;
		abort_in.valid && abort_in.delayed;
	endsequence
	sequence s_dly_read;
		s_dly_abort ##0 abort_in.read;
	endsequence
	a_rd_answer:
		assert property (cfg_rd |=> cfg_rdata_valid) else $error("read not answered");
	a_idle_zero:
		assert property (!cfg_rdata_valid |-> cfg_rdata == 32'h0) else $error("idle data");
	a_reserved_zero:
		assert property (cfg_rdata_valid |-> (cfg_rdata & ~32'h0f68_0000) == 32'h0)
			else $error("reserved bit set");
	a_b2b_off:
		assert property (!sec_fast_b2b_en) else $error("fast b2b enabled");
	a_reset_pair:
		assert property (sec_logic_reset_n == sec_reset_n) else $error("reset pair split");
	a_pin_pair:
		assert property (primary_system_error_oe == !primary_system_error_n)
			else $error("error pin enable split");
	a_abort_answer:
		assert property (s_dly_abort |=> abort_resp.complete_ok != abort_resp.target_abort)
			else $error("delayed abort answer");
	a_abort_ones:
		assert property (s_dly_read |=> !abort_resp.complete_ok || abort_resp.rdata == BCV_ALL_ONES)
			else $error("abort read data");
	a_claim_cause:
		assert property (pri_vga_claim |-> $past(pri_req.valid)) else $error("claim no request");
	a_ignore_cause:
		assert property (sec_vga_ignore |-> $past(sec_req.valid)) else $error("ignore no request");
	a_discard_pulse:
		assert property (pri_discard |=> !pri_discard) else $error("discard too long");
	a_discard_min:
		assert property (pri_discard |-> hold_cnt >= SHORT_CYCLES) else $error("discard early");
endmodule // bcv_bridge_ctrl_props

bind bcv_bridge_ctrl bcv_bridge_ctrl_props #(
	.LONG_CYCLES(LONG_CYCLES),
	.SHORT_CYCLES(SHORT_CYCLES)
) props_u (.core_clk, .resetn, .cfg_rd, .cfg_rdata, .cfg_rdata_valid, .pri_req, .sec_req,
	.pri_vga_claim, .sec_vga_ignore, .abort_in, .abort_resp, .pri_head_valid, .pri_discard,
	.sec_reset_n, .sec_logic_reset_n, .sec_fast_b2b_en, .primary_system_error_n,
	.primary_system_error_oe);

// file: sim/bcv_initiator_model.sv
// Initiator waiting on a delayed completion, repeating after a set wait
`timescale 1ns/1ps
module bcv_initiator_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Control
	input wire logic go,
	input wire logic drop,
	input wire logic [7:0] rpt_after,
	// Towards the bridge
	output logic head_valid,
	output logic repeat_seen
);
	logic [7:0] cnt;
	always_ff @(posedge core_clk) begin
		repeat_seen <= 1'b0;
		if (!resetn || drop) begin
			head_valid <= 1'b0;
		end else if (go) begin
			head_valid <= 1'b1;
			cnt <= 8'h0;
		end else if (head_valid) begin
			cnt <= cnt + 8'h1;
			// Zero wait means the initiator never comes back
			if (rpt_after != 8'h0 && cnt + 8'h1 == rpt_after) begin
				repeat_seen <= 1'b1;
				head_valid <= 1'b0;
			end
		end
	end
endmodule // bcv_initiator_model

// file: sim/bcv_bridge_ctrl_tb.sv
// Self-checking bench for the bridge control block
`timescale 1ns/1ps
module bcv_bridge_ctrl_tb;
	import bcv_pkg::*;
	localparam int LONG_N = 40;
	localparam int SHORT_N = 8;
	logic core_clk, resetn, cfg_wr, cfg_rd, cmd_io_enable, cmd_mem_enable, isa_mode;
	logic system_error_report_enable, pri_io_window_hit, cfg_rdata_valid, sec_fast_b2b_en;
	logic [5:0] cfg_dword;
	logic [3:0] cfg_be_n;
	logic [31:0] cfg_wdata, cfg_rdata;
	logic pri_vga_claim, sec_vga_ignore, pri_discard, sec_discard, sec_reset_n;
	logic sec_logic_reset_n, primary_system_error_n, primary_system_error_oe;
	logic pri_head_valid, pri_repeat_seen, sec_head_valid, sec_repeat_seen, pri_go, sec_go;
	logic [7:0] rpt_after;
	bcv_addr_t pri_req, sec_req;
	bcv_abort_t abort_in;
	bcv_abort_resp_t abort_resp;
	int mismatches, checked, cyc;
	bcv_bridge_ctrl #(.LONG_CYCLES(LONG_N), .SHORT_CYCLES(SHORT_N)) dut_u (.core_clk, .resetn,
		.cfg_wr, .cfg_rd, .cfg_dword, .cfg_be_n, .cfg_wdata, .cfg_rdata, .cfg_rdata_valid,
		.cmd_io_enable, .cmd_mem_enable, .system_error_report_enable, .isa_mode,
		.pri_io_window_hit, .pri_req, .sec_req, .pri_vga_claim, .sec_vga_ignore, .abort_in,
		.abort_resp, .pri_head_valid, .pri_repeat_seen, .sec_head_valid, .sec_repeat_seen,
		.pri_discard, .sec_discard, .sec_reset_n, .sec_logic_reset_n, .sec_fast_b2b_en,
		.primary_system_error_n, .primary_system_error_oe);
	bcv_initiator_model pri_m (.core_clk, .resetn, .go(pri_go), .drop(pri_discard), .rpt_after,
		.head_valid(pri_head_valid), .repeat_seen(pri_repeat_seen));
	bcv_initiator_model sec_m (.core_clk, .resetn, .go(sec_go), .drop(sec_discard), .rpt_after,
		.head_valid(sec_head_valid), .repeat_seen(sec_repeat_seen));
	// ----
	// Helpers
	// ----
	task complete_run;
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task chk(input logic [33:0] got, input logic [33:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [31:0] d, input logic [3:0] be);
		@(posedge core_clk);
		cfg_wr <= 1'b1;
		cfg_dword <= BCV_CTRL_DWORD;
		cfg_be_n <= be;
		cfg_wdata <= d;
		@(posedge core_clk);
		cfg_wr <= 1'b0;
	endtask
	task rd(input logic [5:0] dw, output logic [31:0] d);
		@(posedge core_clk);
		cfg_rd <= 1'b1;
		cfg_dword <= dw;
		@(posedge core_clk);
		cfg_rd <= 1'b0;
		#1;
		d = cfg_rdata;
		chk(cfg_rdata_valid, 1'b1);
	endtask
	task rdx(input logic [5:0] dw, input logic [31:0] e);
		logic [31:0] d;
		rd(dw, d);
		chk(d, e);
	endtask
	task vc(input logic m, input logic [31:0] a, input logic w, i, ec, ei);
		@(posedge core_clk);
		pri_req <= '{1'b1, m, !m, a};
		sec_req <= '{1'b1, m, !m, a};
		pri_io_window_hit <= w;
		isa_mode <= i;
		@(posedge core_clk);
		pri_req <= '0;
		sec_req <= '0;
		#1;
		chk(pri_vga_claim, ec);
		chk(sec_vga_ignore, ei);
	endtask
	task ab(input logic [3:0] a, input logic [1:0] e, input logic es);
		@(posedge core_clk);
		abort_in <= a;
		@(posedge core_clk);
		abort_in <= '0;
		#1;
		chk({abort_resp.complete_ok, abort_resp.target_abort}, e);
		chk(primary_system_error_n, es);
		chk(primary_system_error_oe, !es);
		if (e[1] && a[0]) chk(abort_resp.rdata, BCV_ALL_ONES);
	endtask
	// ----
	// Scenarios
	// ----
	task t_reg;
		rdx(BCV_CTRL_DWORD, BCV_CTRL_RESET);
		chk(sec_reset_n, 1'b1);
		wr(32'hffff_ffff, 4'b1011);
		rdx(BCV_CTRL_DWORD, 32'h0068_0000);
		chk(sec_reset_n, 1'b0);
		chk(sec_logic_reset_n, 1'b0);
		chk(sec_fast_b2b_en, 1'b0);
		wr(32'hffff_ffff, 4'h0);
		rdx(BCV_CTRL_DWORD, 32'h0b68_0000);
		rdx(6'h0e, 32'h0);
		wr(32'h0, 4'h0);
		rdx(BCV_CTRL_DWORD, 32'h0);
		chk(sec_reset_n, 1'b1);
		$display("test reg done");
	endtask
	task t_vga;
		wr(32'h0008_0000, 4'h0);
		vc(1, 32'h000a_0000, 0, 0, 1, 1);
		vc(1, 32'h000b_ffff, 0, 0, 1, 1);
		vc(1, 32'h000c_0000, 0, 0, 0, 0);
		vc(0, 32'h0000_03b0, 1, 1, 1, 1);
		vc(0, 32'h0000_7fdf, 0, 0, 1, 1);
		vc(0, 32'h0001_03c0, 0, 0, 0, 0);
		vc(0, 32'h0000_03bc, 0, 0, 0, 0);
		@(posedge core_clk);
		{cmd_io_enable, cmd_mem_enable} <= 2'b00;
		vc(1, 32'h000a_0000, 0, 0, 0, 1);
		vc(0, 32'h0000_03c0, 0, 0, 0, 1);
		@(posedge core_clk);
		{cmd_io_enable, cmd_mem_enable} <= 2'b11;
		wr(32'h0, 4'h0);
		vc(0, 32'h0000_03b0, 1, 0, 1, 0);
		vc(0, 32'h0000_03b0, 1, 1, 0, 0);
		vc(1, 32'h000a_0000, 0, 0, 0, 0);
		$display("test vga done");
	endtask
	task t_abort;
		ab(4'b1101, 2'b10, 1);
		ab(4'b1010, 2'b00, 1);
		wr(32'h0020_0000, 4'h0);
		ab(4'b1100, 2'b01, 1);
		ab(4'b1010, 2'b00, 0);
		@(posedge core_clk);
		system_error_report_enable <= 1'b0;
		ab(4'b1010, 2'b00, 1);
		@(posedge core_clk);
		system_error_report_enable <= 1'b1;
		wr(32'h0, 4'h0);
		$display("test abort done");
	endtask
	task t_disc(input logic sec, sel, input logic [7:0] rp, input logic en);
		int n;
		logic hit;
		logic [31:0] d;
		d = 32'h0;
		d[27] = en;
		d[24 + sec] = sel;
		wr(d, 4'h0);
		@(posedge core_clk);
		rpt_after <= rp;
		if (sec) sec_go <= 1'b1;
		else pri_go <= 1'b1;
		@(posedge core_clk);
		pri_go <= 1'b0;
		sec_go <= 1'b0;
		n = 0;
		hit = 1'b0;
		while (!hit && n < 60) begin
			@(posedge core_clk);
			#1;
			n++;
			hit = sec ? sec_discard : pri_discard;
		end
		// One cycle after head valid for the timer to leave idle, then the full timer length
		chk(hit ? n : 0, rp != 8'h0 ? 0 : (sel ? SHORT_N : LONG_N) + 1);
		if (hit) begin
			@(posedge core_clk);
			#1;
			chk(primary_system_error_n, !en);
			chk(primary_system_error_oe, en);
		end
		rd(BCV_CTRL_DWORD, d);
		chk(d[26], rp == 8'h0);
		wr(d & ~32'h0400_0000, 4'h0);
		rd(BCV_CTRL_DWORD, d);
		chk(d[26], rp == 8'h0);
		wr(d | 32'h0400_0000, 4'h0);
		rd(BCV_CTRL_DWORD, d);
		chk(d[26], 1'b0);
		wr(32'h0, 4'h0);
		$display("test discard done");
	endtask
	// ----
	// Clock, reset, sequence
	// ----
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			complete_run();
		end
	end
	initial begin
		{resetn, cfg_wr, cfg_rd, isa_mode, pri_io_window_hit, pri_go, sec_go} = '0;
		{cfg_dword, cfg_be_n, cfg_wdata, rpt_after, pri_req, sec_req, abort_in} = '0;
		cmd_io_enable = 1'b1;
		cmd_mem_enable = 1'b1;
		system_error_report_enable = 1'b1;
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		t_reg();
		t_vga();
		t_abort();
		t_disc(0, 1, 8'h0, 1);
		t_disc(1, 0, 8'h0, 0);
		t_disc(1, 1, 8'h3, 1);
		complete_run();
	end
endmodule // bcv_bridge_ctrl_tb
